// >>> dv/rsc_bus_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "rsc_defines.vh"
module rsc_bus_ctrl (
    input wire logic                   clk_sys,  // Clock
    input wire logic                   cmdReady, // Take
    output logic                       cmdValid, // Request
    output logic [`RSC_OP_W-1:0]       cmdOp,    // Opcode
    output logic [`RSC_IDX_W-1:0]      cmdArgA,  // Source
    output logic [`RSC_IDX_W-1:0]      cmdArgB,  // Destination
    output logic [5:0]                 cmdXpoint // Crosspoint
);
    initial
    begin
        cmdValid = 1'b0;
        {cmdOp, cmdArgA, cmdArgB, cmdXpoint} = 23'h0;
    end
    // Released fields flip so stale values never look valid
    // Gives up after 50 cycles; taken tells the caller so it can count the miss
    task automatic send(input logic [2:0] op, input logic [6:0] a, input logic [6:0] b, input logic [5:0] x,
                        output logic taken);
        logic rdy;
        int   n;
        @(posedge clk_sys);
        cmdValid <= 1'b1;
        {cmdOp, cmdArgA, cmdArgB, cmdXpoint} <= {op, a, b, x};
        rdy = 1'b0;
        n = 0;
        while (!rdy && n < 50)
        begin
            @(negedge clk_sys);
            rdy = cmdReady;
            @(posedge clk_sys);
            n++;
        end
        cmdValid <= 1'b0;
        {cmdOp, cmdArgA, cmdArgB, cmdXpoint} <= ~{op, a, b, x};
        taken = rdy;
    endtask
endmodule
`default_nettype wire

// >>> dv/rsc_relay_exec_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "rsc_defines.vh"
module rsc_relay_exec_asserts #(
    parameter NXP       = 64,
    parameter TX_CYCLES = 10
) (
    input wire logic                  clk_sys,     // Clock
    input wire logic                  reset_n,     // Reset
    input wire logic                  cmdValid,    // Request
    input wire logic                  cmdReady,    // Take
    input wire logic [`RSC_OP_W-1:0]  cmdOp,       // Opcode
    input wire logic [`RSC_IDX_W-1:0] cmdArgA,     // Source
    input wire logic [`RSC_IDX_W-1:0] cmdArgB,     // Destination
    input wire logic [NXP-1:0]        relayPat_r,  // Relays
    input wire logic                  relayLoad_r, // Strobe
    input wire logic                  holdOff_r,   // Hold-off
    input wire logic [`RSC_IDX_W-1:0] stepPtr_r,   // Step pointer
    input wire logic                  cmdError_r,  // Error
    input wire logic                  txPace_r     // Pace
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    localparam int PACE_LAST = TX_CYCLES - 1;
    // ----------------------------------------
    // Pace gap counter
    // ----------------------------------------
    logic [31:0] gapCnt_r;
    logic        seenPace_r;
    always_ff @(posedge clk_sys)
    begin
        gapCnt_r   <= (!reset_n || txPace_r) ? 32'h0 : gapCnt_r + 32'h1;
        seenPace_r <= reset_n && (seenPace_r || txPace_r);
    end
    sequence execTake;
        cmdValid && cmdReady && cmdOp == `RSC_OP_EXECUTE;
    endsequence
    sequence badCmd;
        cmdValid && cmdReady && (cmdOp > `RSC_OP_EXECUTE || (cmdOp == `RSC_OP_EDIT && cmdArgA > `RSC_IDX_MAX)
            || (cmdOp == `RSC_OP_COPY && (cmdArgA > `RSC_IDX_MAX || cmdArgB > `RSC_IDX_MAX)));
    endsequence
    a_ready_in_hold: assert property (holdOff_r |-> !cmdReady) else $error("ready during hold-off");
    a_exec_raises_hold: assert property (execTake |=> holdOff_r) else $error("no hold-off");
    a_hold_bounded: assert property ($rose(holdOff_r) |-> ##[1:8] !holdOff_r) else $error("hold-off stuck");
    a_pat_needs_load: assert property (!relayLoad_r |-> $stable(relayPat_r)) else $error("relays moved");
    a_load_single: assert property (relayLoad_r |=> !relayLoad_r) else $error("double switch");
    a_load_in_hold: assert property (relayLoad_r |-> $past(holdOff_r)) else $error("switch outside exec");
    a_step_needs_load: assert property (!relayLoad_r |-> $stable(stepPtr_r)) else $error("step moved");
    a_bad_arg_err: assert property (badCmd |=> cmdError_r) else $error("no error pulse");
    a_tx_pace_gap: assert property (seenPace_r |-> (txPace_r ? gapCnt_r == PACE_LAST : gapCnt_r < PACE_LAST))
        else $error("pace gap wrong");
endmodule
bind rsc_relay_exec rsc_relay_exec_asserts #(.NXP(NXP), .TX_CYCLES(TX_CYCLES)) rsc_relay_exec_asserts_inst (
    .clk_sys(clk_sys), .reset_n(reset_n), .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdOp(cmdOp),
    .cmdArgA(cmdArgA), .cmdArgB(cmdArgB), .relayPat_r(relayPat_r), .relayLoad_r(relayLoad_r),
    .holdOff_r(holdOff_r), .stepPtr_r(stepPtr_r), .cmdError_r(cmdError_r), .txPace_r(txPace_r));
`default_nettype wire

// >>> dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "rsc_defines.vh"
module testbench;
    logic clk_sys, reset_n, cmdValid, cmdReady, relayLoad_r, holdOff_r, cmdError_r, txPace_r;
    logic [2:0]  cmdOp;
    logic [6:0]  cmdArgA, cmdArgB, stepPtr_r, editPtr_r;
    logic [5:0]  cmdXpoint;
    logic [63:0] relayPat_r;
    int errors, tests_run, loads, errs, paces;
    localparam int TX_SIM = 10;
    rsc_relay_exec #(.TX_CYCLES(TX_SIM)) rsc_relay_exec_inst (.clk_sys(clk_sys), .reset_n(reset_n),
        .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdOp(cmdOp), .cmdArgA(cmdArgA), .cmdArgB(cmdArgB),
        .cmdXpoint(cmdXpoint), .relayPat_r(relayPat_r), .relayLoad_r(relayLoad_r), .holdOff_r(holdOff_r),
        .stepPtr_r(stepPtr_r), .editPtr_r(editPtr_r), .cmdError_r(cmdError_r), .txPace_r(txPace_r));
    rsc_bus_ctrl rsc_bus_ctrl_inst (.clk_sys(clk_sys), .cmdReady(cmdReady), .cmdValid(cmdValid),
        .cmdOp(cmdOp), .cmdArgA(cmdArgA), .cmdArgB(cmdArgB), .cmdXpoint(cmdXpoint));
    initial
    begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys)
    begin
        if (relayLoad_r === 1'b1) loads++;
        if (cmdError_r === 1'b1) errs++;
        if (txPace_r === 1'b1) paces++;
    end
    task check(input logic [63:0] seen, input logic [63:0] exp, input string what);
        tests_run++;
        if (seen !== exp)
        begin
            errors++;
            $display("FAIL %0t %s", $time, what);
        end
    endtask
    task final_report;
        $display("errors=%0d checks=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task send(input logic [2:0] op, input logic [6:0] a, input logic [6:0] b, input logic [5:0] x);
        logic tk;
        rsc_bus_ctrl_inst.send(op, a, b, x, tk);
        check(tk, 64'h1, "command taken");
    endtask
    task exec;
        send(`RSC_OP_EXECUTE, 7'h00, 7'h00, 6'h00);
        repeat (2) @(negedge clk_sys);
        for (int n = 0; n < 20 && holdOff_r !== 1'b0; n++) @(negedge clk_sys);
        check(holdOff_r, 64'h0, "hold-off ends");
        // Strobe rises no later than the edge where hold-off drops; let the load counter see it
        @(negedge clk_sys);
    endtask
    task t_live_edit;
        loads = 0;
        send(`RSC_OP_EDIT, 7'h00, 7'h00, 6'h00);
        send(`RSC_OP_XCLOSE, 7'h00, 7'h00, 6'h01);
        send(`RSC_OP_OPENALL, 7'h00, 7'h00, 6'h00);
        exec();
        check(relayPat_r, 64'h2, "close after open-all");
        check(loads, 64'h1, "one switch");
        check(editPtr_r, 64'h0, "edit on live");
    endtask
    task t_store;
        loads = 0;
        errs = 0;
        send(`RSC_OP_COPY, 7'h00, 7'h0A, 6'h00);
        exec();
        send(`RSC_OP_COPY, 7'h0A, 7'h14, 6'h00);
        exec();
        send(`RSC_OP_COPY, 7'h00, 7'h64, 6'h00);
        exec();
        check(relayPat_r, 64'h2, "relays kept");
        check(stepPtr_r, 64'h0, "step kept");
        check(loads, 64'h0, "no switch");
        check(errs, 64'h0, "index 100 taken");
    endtask
    task t_copy_merge;
        send(`RSC_OP_OPENALL, 7'h00, 7'h00, 6'h00);
        send(`RSC_OP_XCLOSE, 7'h00, 7'h00, 6'h03);
        exec();
        check(relayPat_r, 64'h8, "relays before copy");
        loads = 0;
        send(`RSC_OP_XCLOSE, 7'h00, 7'h00, 6'h05);
        send(`RSC_OP_XOPEN, 7'h00, 7'h00, 6'h01);
        send(`RSC_OP_COPY, 7'h14, 7'h00, 6'h00);
        exec();
        check(relayPat_r, 64'h20, "forced crosspoints");
        check(stepPtr_r, 64'h14, "step to source");
        check(loads, 64'h1, "single switch");
    endtask
    task t_zero_copy;
        loads = 0;
        send(`RSC_OP_COPY, 7'h00, 7'h00, 6'h00);
        exec();
        check(relayPat_r, 64'h20, "relays same");
        check(stepPtr_r, 64'h0, "step cleared");
        check(loads, 64'h1, "re-send");
    endtask
    task t_refuse;
        errs = 0;
        send(`RSC_OP_COPY, 7'h65, 7'h00, 6'h00);
        send(3'h7, 7'h00, 7'h00, 6'h00);
        repeat (2) @(negedge clk_sys);
        check(errs, 64'h2, "refused commands");
        exec();
        check(relayPat_r, 64'h20, "nothing applied");
    endtask
    task t_slot_edit;
        loads = 0;
        send(`RSC_OP_EDIT, 7'h0A, 7'h00, 6'h00);
        send(`RSC_OP_XCLOSE, 7'h00, 7'h00, 6'h04);
        exec();
        check(relayPat_r, 64'h20, "stored edit leaves relays");
        check(loads, 64'h0, "no switch on stored edit");
        send(`RSC_OP_EDIT, 7'h00, 7'h00, 6'h00);
        send(`RSC_OP_COPY, 7'h0A, 7'h00, 6'h00);
        exec();
        check(relayPat_r, 64'h12, "edited slot on relays");
        check(stepPtr_r, 64'h0A, "step to edited slot");
        check(loads, 64'h1, "edited slot switch");
    endtask
    task t_pace;
        paces = 0;
        repeat (3 * TX_SIM) @(negedge clk_sys);
        check(paces, 64'h3, "pace pulses");
    endtask
    initial
    begin
        errors = 0;
        tests_run = 0;
        reset_n = 1'b0;
        repeat (5) @(posedge clk_sys);
        reset_n <= 1'b1;
        t_live_edit();
        t_store();
        t_copy_merge();
        t_zero_copy();
        t_refuse();
        t_slot_edit();
        t_pace();
        final_report();
    end
    // Whole sequence needs well under a thousand cycles
    initial
    begin
        #20000;
        errors++;
        final_report();
    end
endmodule
`default_nettype wire

// >>> logic/rsc_relay_exec.v
`timescale 1ns/1ps
`default_nettype none
`include "rsc_defines.vh"

module rsc_relay_exec #(
    parameter NXP        = 64,     // Crosspoints in matrix
    parameter XW         = 6,      // Crosspoint index width
    parameter TX_CYCLES  = `RSC_TX_CHAR_US * `RSC_CLK_MHZ
) (
    input  wire                  clk_sys,     // System clock
    input  wire                  reset_n,     // Synchronous reset, active low
    input  wire                  cmdValid,    // Parsed command present
    output wire                  cmdReady,    // Command taken when both high
    input  wire [`RSC_OP_W-1:0]  cmdOp,       // Command opcode
    input  wire [`RSC_IDX_W-1:0] cmdArgA,     // Pointer or copy source
    input  wire [`RSC_IDX_W-1:0] cmdArgB,     // Copy destination
    input  wire [XW-1:0]         cmdXpoint,   // Crosspoint for open/close
    output reg  [NXP-1:0]        relayPat_r,  // Relay drive pattern
    output reg                   relayLoad_r, // One-cycle switching strobe
    output reg                   holdOff_r,   // Bus hold-off
    output reg  [`RSC_IDX_W-1:0] stepPtr_r,   // Relay step pointer
    output reg  [`RSC_IDX_W-1:0] editPtr_r,   // Edit pointer
    output reg                   cmdError_r,  // Pulse: argument out of range or unknown opcode
    output reg                   txPace_r     // Pulse: next outgoing character
);

    // ------------------------------------------------------------------
    // States and helpers
    // ------------------------------------------------------------------
    localparam [6:0] S_IDLE  = 7'h01;
    localparam [6:0] S_RDSRC = 7'h02;
    localparam [6:0] S_WTSRC = 7'h04;
    localparam [6:0] S_APPLY = 7'h08;
    localparam [6:0] S_RDED  = 7'h10;
    localparam [6:0] S_WTED  = 7'h20;
    localparam [6:0] S_WRED  = 7'h40;

    localparam [31:0] TX_LAST = TX_CYCLES - 1;

    function [NXP-1:0] mergeEdits;
        input [NXP-1:0] base;
        input [NXP-1:0] openM;
        input [NXP-1:0] closeM;
        begin
            mergeEdits = (base & ~openM) | closeM;
        end
    endfunction

    function inRange;
        input [`RSC_IDX_W-1:0] idx;
        begin
            inRange = (idx <= `RSC_IDX_MAX);
        end
    endfunction

    // ------------------------------------------------------------------
    // Pending string state
    // ------------------------------------------------------------------
    reg [6:0]            state_r;
    reg [6:0]            state_nxt;
    reg                  openAllPend_r;
    reg                  copyPend_r;
    reg [`RSC_IDX_W-1:0] copySrc_r;
    reg [`RSC_IDX_W-1:0] copyDst_r;
    reg [NXP-1:0]        openMask_r;
    reg [NXP-1:0]        closeMask_r;
    reg [NXP-1:0]        workPat_r;
    reg [31:0]           txCnt_r;
    reg                  cmdReady_r;

    reg                  memWrEn;
    reg [`RSC_IDX_W-1:0] memWrAddr;
    reg [NXP-1:0]        memWrData;
    reg [`RSC_IDX_W-1:0] memRdAddr;
    wire [NXP-1:0]       memRdData;

    wire take     = cmdValid && cmdReady;
    wire editLive = (editPtr_r == `RSC_IDX_LIVE);
    wire anyEdit  = |(openMask_r | closeMask_r);
    wire [NXP-1:0] xpBit = {{(NXP-1){1'b0}}, 1'b1} << cmdXpoint;

    assign cmdReady = cmdReady_r;

    rsc_setup_mem #(
        .WIDTH (NXP),
        .DEPTH (`RSC_MEM_DEPTH),
        .AW    (`RSC_IDX_W)
    ) uMem (
        .clk_sys  (clk_sys),
        .wrEn     (memWrEn),
        .wrAddr   (memWrAddr),
        .wrData   (memWrData),
        .rdAddr   (memRdAddr),
        .rdData_r (memRdData)
    );

    // ------------------------------------------------------------------
    // Execution sequencer
    // ------------------------------------------------------------------
    always @*
    begin
        state_nxt = state_r;
        memWrEn   = 1'b0;
        memWrAddr = copyDst_r;
        memWrData = workPat_r;
        memRdAddr = copySrc_r;
        case (state_r)
            S_IDLE:
            begin
                if (take && cmdOp == `RSC_OP_EXECUTE)
                begin
                    state_nxt = (copyPend_r && copySrc_r != `RSC_IDX_LIVE) ? S_RDSRC : S_APPLY;
                end
            end
            S_RDSRC: state_nxt = S_WTSRC;
            S_WTSRC: state_nxt = S_APPLY;
            S_APPLY:
            begin
                // Copy into a stored slot happens here, before stored edits
                memWrEn   = copyPend_r && copyDst_r != `RSC_IDX_LIVE;
                state_nxt = (!editLive && anyEdit) ? S_RDED : S_IDLE;
            end
            S_RDED:
            begin
                memRdAddr = editPtr_r;
                state_nxt = S_WTED;
            end
            S_WTED:
            begin
                memRdAddr = editPtr_r;
                state_nxt = S_WRED;
            end
            S_WRED:
            begin
                memWrEn   = 1'b1;
                memWrAddr = editPtr_r;
                memWrData = mergeEdits(memRdData, openMask_r, closeMask_r);
                state_nxt = S_IDLE;
            end
            default: state_nxt = S_IDLE;
        endcase
    end

    always @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            state_r       <= S_IDLE;
            openAllPend_r <= 1'b0;
            copyPend_r    <= 1'b0;
            copySrc_r     <= `RSC_IDX_LIVE;
            copyDst_r     <= `RSC_IDX_LIVE;
            openMask_r    <= {NXP{1'b0}};
            closeMask_r   <= {NXP{1'b0}};
            workPat_r     <= {NXP{1'b0}};
            relayPat_r    <= {NXP{1'b0}};
            relayLoad_r   <= 1'b0;
            holdOff_r     <= 1'b0;
            stepPtr_r     <= `RSC_IDX_LIVE;
            editPtr_r     <= `RSC_IDX_LIVE;
            cmdError_r    <= 1'b0;
            cmdReady_r    <= 1'b1;
        end
        else
        begin
            state_r     <= state_nxt;
            // Hold-off spans every non-idle state, so idle next means ready next
            cmdReady_r  <= (state_nxt == S_IDLE);
            relayLoad_r <= 1'b0;
            cmdError_r  <= 1'b0;
            // Collect the string; nothing touches relays until execute
            if (take)
            begin
                case (cmdOp)
                    `RSC_OP_EDIT:
                    begin
                        if (inRange(cmdArgA))
                            editPtr_r <= cmdArgA;
                        else
                            cmdError_r <= 1'b1;
                    end
                    `RSC_OP_OPENALL: openAllPend_r <= 1'b1;
                    `RSC_OP_COPY:
                    begin
                        if (inRange(cmdArgA) && inRange(cmdArgB))
                        begin
                            copyPend_r <= 1'b1;
                            copySrc_r  <= cmdArgA;
                            copyDst_r  <= cmdArgB;
                        end
                        else
                        begin
                            cmdError_r <= 1'b1;
                        end
                    end
                    `RSC_OP_XOPEN:
                    begin
                        openMask_r  <= openMask_r | xpBit;
                        closeMask_r <= closeMask_r & ~xpBit;
                    end
                    `RSC_OP_XCLOSE:
                    begin
                        closeMask_r <= closeMask_r | xpBit;
                        openMask_r  <= openMask_r & ~xpBit;
                    end
                    `RSC_OP_EXECUTE:
                    begin
                        holdOff_r <= 1'b1;
                        // Open-all precedes the copy so a live source sees it
                        workPat_r <= openAllPend_r ? {NXP{1'b0}} : relayPat_r;
                    end
                    default: cmdError_r <= 1'b1;
                endcase
            end
            if (state_r == S_WTSRC)
            begin
                workPat_r <= memRdData;
            end
            if (state_r == S_APPLY)
            begin
                // Live pattern: open-all, then copy-to-relays, then edits
                if (openAllPend_r || (copyPend_r && copyDst_r == `RSC_IDX_LIVE) || (editLive && anyEdit))
                begin
                    relayLoad_r <= 1'b1;
                end
                if (copyPend_r && copyDst_r == `RSC_IDX_LIVE)
                begin
                    relayPat_r <= editLive ? mergeEdits(workPat_r, openMask_r, closeMask_r) : workPat_r;
                    stepPtr_r  <= copySrc_r;
                end
                else if (openAllPend_r)
                begin
                    relayPat_r <= editLive ? mergeEdits({NXP{1'b0}}, openMask_r, closeMask_r) : {NXP{1'b0}};
                end
                else if (editLive)
                begin
                    relayPat_r <= mergeEdits(relayPat_r, openMask_r, closeMask_r);
                end
                openAllPend_r <= 1'b0;
                copyPend_r    <= 1'b0;
            end
            if (state_r != S_IDLE && state_nxt == S_IDLE)
            begin
                holdOff_r   <= 1'b0;
                openMask_r  <= {NXP{1'b0}};
                closeMask_r <= {NXP{1'b0}};
            end
        end
    end

    // ------------------------------------------------------------------
    // Outgoing character pacing
    // ------------------------------------------------------------------
    // Free-running so an upload engine can sync to the next tick
    always @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            txCnt_r  <= 32'h00000000;
            txPace_r <= 1'b0;
        end
        else
        begin
            txPace_r <= (txCnt_r == TX_LAST);
            txCnt_r  <= (txCnt_r == TX_LAST) ? 32'h00000000 : txCnt_r + 32'h00000001;
        end
    end

endmodule
`default_nettype wire

// >>> logic/rsc_relay_exec_note.v
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// >>> logic/rsc_setup_mem.v
`timescale 1ns/1ps
`default_nettype none

module rsc_setup_mem #(
    parameter WIDTH = 64,
    parameter DEPTH = 128,
    parameter AW    = 7
) (
    input  wire             clk_sys,  // System clock
    input  wire             wrEn,     // Write strobe
    input  wire [AW-1:0]    wrAddr,   // Write slot
    input  wire [WIDTH-1:0] wrData,   // Write pattern
    input  wire [AW-1:0]    rdAddr,   // Read slot
    output reg  [WIDTH-1:0] rdData_r  // Read pattern, one cycle late
);

    reg [WIDTH-1:0] store [0:DEPTH-1];

    // No reset: slots hold whatever software last stored
    always @(posedge clk_sys)
    begin
        if (wrEn)
        begin
            store[wrAddr] <= wrData;
        end
        rdData_r <= store[rdAddr];
    end

endmodule
`default_nettype wire

// >>> shared/rsc_defines.vh
`ifndef RSC_DEFINES_VH
`define RSC_DEFINES_VH

// ----------------------------------------------------------------------
// Command opcodes from the string parser
// ----------------------------------------------------------------------
`define RSC_OP_W        3
`define RSC_OP_EDIT     3'h0
`define RSC_OP_OPENALL  3'h1
`define RSC_OP_COPY     3'h2
`define RSC_OP_XOPEN    3'h3
`define RSC_OP_XCLOSE   3'h4
`define RSC_OP_EXECUTE  3'h5

// ----------------------------------------------------------------------
// Setup indices
// ----------------------------------------------------------------------
`define RSC_IDX_W       7
`define RSC_IDX_LIVE    7'h00
`define RSC_IDX_MAX     7'h64
`define RSC_MEM_DEPTH   128

// ----------------------------------------------------------------------
// Character timing
// ----------------------------------------------------------------------
`define RSC_CLK_MHZ     250
`define RSC_RX_CHAR_US  250
`define RSC_TX_CHAR_US  400

`endif
